//--- verilog/ndai_top.v
// Namespace deallocate features and atomic unit reporting, APB slave.
// Assumes an APB master on pclk and a write path that polls the boundary check.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "ndai_defines.vh"
module ndai_top #(
   parameter AW = 12,
   parameter LBAW = 32
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire subsys_wz_dealloc,
   output reg [7:0] deallocate_read_features,
   output reg [15:0] guard_value,
   output reg [15:0] eff_atomic_normal,
   output reg [15:0] eff_atomic_powerfail,
   output reg [15:0] eff_atomic_compare_write
);
   reg [31:0] cfg;
   reg [15:0] ns_atomic_unit_normal;
   reg [15:0] ns_atomic_unit_powerfail;
   reg [15:0] ns_atomic_compare_write_unit;
   reg [15:0] ns_atomic_boundary_normal;
   reg [15:0] ctrl_atomic_unit_normal;
   reg [15:0] ctrl_atomic_unit_powerfail;
   reg [15:0] ctrl_atomic_compare_write_unit;
   reg [15:0] crc_run;
   reg [LBAW-1:0] chk_slba;
   reg [15:0] chk_nlb;
   reg chk_cross;
   reg next_cross;
   reg wz_s1;
   reg wz_s2;
   reg [31:0] next_prdata;
   reg next_err;
   reg [2:0] drv_code;
   reg [7:0] feat_byte;
   reg [LBAW-1:0] first_reg;
   reg [LBAW-1:0] last_reg;
   reg [LBAW-1:0] last_lba;
   wire [15:0] crc_next;
   wire [15:0] sel_n;
   wire [15:0] sel_pf;
   wire [15:0] sel_cw;
   wire acc;
   wire wr;
   wire guard_mode;
   wire [7:0] crc_byte;

   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign guard_mode = cfg[`NDAI_GRD_BIT];
   assign crc_byte = cfg[15:8];

   // Subsystem strap comes from another domain
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wz_s1 <= 1'b0;
         wz_s2 <= 1'b0;
      end
      else
      begin
         wz_s1 <= subsys_wz_dealloc;
         wz_s2 <= wz_s1;
      end
   end

   // Reserved value codes are masked to not reported
   always @*
   begin
      drv_code = cfg[`NDAI_DRV_MSB:`NDAI_DRV_LSB];
      if (drv_code != `NDAI_DRV_ZERO && drv_code != `NDAI_DRV_ONES)
      begin
         drv_code = `NDAI_DRV_NONE;
      end
      feat_byte = 8'h00;
      feat_byte[`NDAI_DRV_MSB:`NDAI_DRV_LSB] = drv_code;
      feat_byte[`NDAI_WZD_BIT] = wz_s2;
      feat_byte[`NDAI_GRD_BIT] = guard_mode;
   end

   ndai_crc16 #(
      .POLY(`NDAI_CRC_POLY)
   ) u_crc (
      .crc_in(crc_run),
      .data(crc_byte),
      .crc_out(crc_next)
   );

   ndai_unit_sel #(
      .W(16)
   ) u_sel_n (
      .ns_unit(ns_atomic_unit_normal),
      .ctrl_unit(ctrl_atomic_unit_normal),
      .eff_unit(sel_n)
   );

   ndai_unit_sel #(
      .W(16)
   ) u_sel_pf (
      .ns_unit(ns_atomic_unit_powerfail),
      .ctrl_unit(ctrl_atomic_unit_powerfail),
      .eff_unit(sel_pf)
   );

   ndai_unit_sel #(
      .W(16)
   ) u_sel_cw (
      .ns_unit(ns_atomic_compare_write_unit),
      .ctrl_unit(ctrl_atomic_compare_write_unit),
      .eff_unit(sel_cw)
   );

   // Boundary region of first and last block of a checked write
   always @*
   begin
      next_cross = 1'b0;
      last_lba = chk_slba + {{(LBAW-16){1'b0}}, chk_nlb};
      if (ns_atomic_boundary_normal == 16'h0000)
      begin
         first_reg = {LBAW{1'b0}};
         last_reg = {LBAW{1'b0}};
      end
      else
      begin
         first_reg = chk_slba / {{(LBAW-16){1'b0}}, ns_atomic_boundary_normal};
         last_reg = last_lba / {{(LBAW-16){1'b0}}, ns_atomic_boundary_normal};
         // A write that stays in one region is atomic
         if (first_reg != last_reg)
         begin
            next_cross = 1'b1;
         end
      end
   end

   // Read mux and unmapped decode
   always @*
   begin
      next_prdata = 32'h0000_0000;
      next_err = 1'b0;
      if (paddr == `NDAI_OFF_CFG)
      begin
         next_prdata = {16'h0000, cfg[15:8], 3'b000, cfg[4:0]};
      end
      else if (paddr == `NDAI_OFF_ATOM0)
      begin
         next_prdata = {ns_atomic_unit_powerfail, ns_atomic_unit_normal};
      end
      else if (paddr == `NDAI_OFF_ATOM1)
      begin
         next_prdata = {ns_atomic_boundary_normal, ns_atomic_compare_write_unit};
      end
      else if (paddr == `NDAI_OFF_CTRL0)
      begin
         next_prdata = {ctrl_atomic_unit_powerfail, ctrl_atomic_unit_normal};
      end
      else if (paddr == `NDAI_OFF_CTRL1)
      begin
         next_prdata = {16'h0000, ctrl_atomic_compare_write_unit};
      end
      else if (paddr == `NDAI_OFF_IDW0)
      begin
         // Identify bytes 32..35 as seen by the host, byte 32 outside here
         next_prdata = {ns_atomic_unit_normal, feat_byte, 8'h00};
      end
      else if (paddr == `NDAI_OFF_IDW1)
      begin
         // Identify bytes 36..39
         next_prdata = {ns_atomic_compare_write_unit, ns_atomic_unit_powerfail};
      end
      else if (paddr == `NDAI_OFF_STAT)
      begin
         next_prdata = {guard_value, 15'h0000, chk_cross};
      end
      else if (paddr == `NDAI_OFF_GCHK)
      begin
         next_prdata = {16'h0000, chk_nlb};
      end
      else
      begin
         next_err = 1'b1;
      end
   end

   // APB slave, zero wait states, pready high in each access phase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & next_err;
         if (psel & ~penable & ~pwrite)
         begin
            prdata <= next_prdata;
         end
      end
   end

   // Register writes at the completing access edge
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg <= `NDAI_CFG_RST;
         ns_atomic_unit_normal <= 16'h0000;
         ns_atomic_unit_powerfail <= 16'h0000;
         ns_atomic_compare_write_unit <= 16'h0000;
         ns_atomic_boundary_normal <= 16'h0000;
         ctrl_atomic_unit_normal <= 16'h0000;
         ctrl_atomic_unit_powerfail <= 16'h0000;
         ctrl_atomic_compare_write_unit <= 16'h0000;
         chk_slba <= {LBAW{1'b0}};
         chk_nlb <= 16'h0000;
      end
      else if (wr & pready & ~pslverr)
      begin
         if (paddr == `NDAI_OFF_CFG)
         begin
            if (pstrb[0])
            begin
               cfg[7:0] <= {3'b000, pwdata[4:0]};
            end
            if (pstrb[1])
            begin
               // Feeding a byte steps the guard CRC over returned content
               cfg[15:8] <= pwdata[15:8];
            end
         end
         else if (paddr == `NDAI_OFF_ATOM0)
         begin
            if (pstrb[0]) ns_atomic_unit_normal[7:0] <= pwdata[7:0];
            if (pstrb[1]) ns_atomic_unit_normal[15:8] <= pwdata[15:8];
            if (pstrb[2]) ns_atomic_unit_powerfail[7:0] <= pwdata[23:16];
            if (pstrb[3]) ns_atomic_unit_powerfail[15:8] <= pwdata[31:24];
         end
         else if (paddr == `NDAI_OFF_ATOM1)
         begin
            if (pstrb[0]) ns_atomic_compare_write_unit[7:0] <= pwdata[7:0];
            if (pstrb[1]) ns_atomic_compare_write_unit[15:8] <= pwdata[15:8];
            if (pstrb[2]) ns_atomic_boundary_normal[7:0] <= pwdata[23:16];
            if (pstrb[3]) ns_atomic_boundary_normal[15:8] <= pwdata[31:24];
         end
         else if (paddr == `NDAI_OFF_CTRL0)
         begin
            if (pstrb[0]) ctrl_atomic_unit_normal[7:0] <= pwdata[7:0];
            if (pstrb[1]) ctrl_atomic_unit_normal[15:8] <= pwdata[15:8];
            if (pstrb[2]) ctrl_atomic_unit_powerfail[7:0] <= pwdata[23:16];
            if (pstrb[3]) ctrl_atomic_unit_powerfail[15:8] <= pwdata[31:24];
         end
         else if (paddr == `NDAI_OFF_CTRL1)
         begin
            if (pstrb[0]) ctrl_atomic_compare_write_unit[7:0] <= pwdata[7:0];
            if (pstrb[1]) ctrl_atomic_compare_write_unit[15:8] <= pwdata[15:8];
         end
         else if (paddr == `NDAI_OFF_STAT)
         begin
            chk_slba <= pwdata[LBAW-1:0];
         end
         else if (paddr == `NDAI_OFF_GCHK)
         begin
            chk_nlb <= pwdata[15:0];
         end
      end
   end

   // Guard CRC, one step per CFG write setup that carries the byte lane
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         crc_run <= `NDAI_CRC_SEED;
      end
      else if (wr & pready & ~pslverr & (paddr == `NDAI_OFF_CFG) & pstrb[2] & pwdata[16])
      begin
         // Reseed at the completing access edge
         crc_run <= `NDAI_CRC_SEED;
      end
      else if (psel & ~penable & pwrite & (paddr == `NDAI_OFF_CFG) & pstrb[1])
      begin
         crc_run <= crc_next;
      end
   end

   // Outputs, boundary check and guard selection
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         deallocate_read_features <= 8'h00;
         guard_value <= `NDAI_GUARD_ONES;
         eff_atomic_normal <= 16'h0000;
         eff_atomic_powerfail <= 16'h0000;
         eff_atomic_compare_write <= 16'h0000;
         chk_cross <= 1'b0;
      end
      else
      begin
         deallocate_read_features <= feat_byte;
         eff_atomic_normal <= sel_n;
         eff_atomic_powerfail <= sel_pf;
         eff_atomic_compare_write <= sel_cw;
         // No boundaries when size is zero; else flag a crossing write
         chk_cross <= next_cross;
         if (guard_mode)
         begin
            guard_value <= crc_run;
         end
         else
         begin
            guard_value <= `NDAI_GUARD_ONES;
         end
      end
   end
endmodule // ndai_top

//--- verilog/ndai_defines.vh
// Constants for the namespace deallocate and atomic capability block.
// Assumes an APB slave with 32-bit aligned word registers.
`ifndef NDAI_DEFINES_VH
`define NDAI_DEFINES_VH
// Register byte offsets
`define NDAI_OFF_CFG 12'h000
`define NDAI_OFF_ATOM0 12'h004
`define NDAI_OFF_ATOM1 12'h008
`define NDAI_OFF_CTRL0 12'h00C
`define NDAI_OFF_CTRL1 12'h010
`define NDAI_OFF_IDW0 12'h014
`define NDAI_OFF_IDW1 12'h018
`define NDAI_OFF_STAT 12'h01C
`define NDAI_OFF_GCHK 12'h020
// Identify byte offsets of the fields
`define NDAI_IDB_DEALLOC 8'd33
`define NDAI_IDB_CTRL_ATOMIC_UNIT_NORMAL 8'd34
// Deallocate read feature field layout
`define NDAI_DRV_LSB 0
`define NDAI_DRV_MSB 2
`define NDAI_WZD_BIT 3
`define NDAI_GRD_BIT 4
// Deallocate read value codes
`define NDAI_DRV_NONE 3'h0
`define NDAI_DRV_ZERO 3'h1
`define NDAI_DRV_ONES 3'h2
// Reset values and CRC polynomial
`define NDAI_CFG_RST 32'h0000_0001
`define NDAI_ATOM_RST 32'h0000_0000
`define NDAI_GUARD_ONES 16'hFFFF
`define NDAI_CRC_POLY 16'h8BB7
`define NDAI_CRC_SEED 16'h0000
`endif

//--- verilog/ndai_crc16.v
// CRC16 over one data byte for the guard of deallocated blocks.
// Assumes the caller holds the running value and steps one byte at a time.
`timescale 1ns/10ps
module ndai_crc16 #(
   parameter [15:0] POLY = 16'h8BB7
) (
   input wire [15:0] crc_in,
   input wire [7:0] data,
   output reg [15:0] crc_out
);
   integer i;
   reg [15:0] c;
   always @*
   begin
      c = crc_in;
      for (i = 7; i >= 0; i = i - 1)
      begin
         if (c[15] ^ data[i])
         begin
            c = {c[14:0], 1'b0} ^ POLY;
         end
         else
         begin
            c = {c[14:0], 1'b0};
         end
      end
      crc_out = c;
   end
endmodule // ndai_crc16

//--- verilog/ndai_unit_sel.v
// Picks the namespace atomic unit or falls back to the controller value.
// Assumes both inputs use the same logical-block encoding.
`timescale 1ns/10ps
module ndai_unit_sel #(
   parameter W = 16
) (
   input wire [W-1:0] ns_unit,
   input wire [W-1:0] ctrl_unit,
   output wire [W-1:0] eff_unit
);
   // Zero means inherit the controller-wide size
   assign eff_unit = (ns_unit == {W{1'b0}}) ? ctrl_unit : ns_unit;
endmodule // ndai_unit_sel

//--- dv/ndai_asserts.sv
// Port checker for the deallocate and atomic capability block.
// Assumes it is bound to ndai_top and sees only its ports.
`timescale 1ns/10ps
module ndai_asserts #(
   parameter AW = 12,
   parameter LBAW = 32
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire subsys_wz_dealloc,
   input wire [7:0] deallocate_read_features,
   input wire [15:0] guard_value,
   input wire [15:0] eff_atomic_normal,
   input wire [15:0] eff_atomic_powerfail,
   input wire [15:0] eff_atomic_compare_write
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_ns_wr;
      pready && pwrite && paddr == 12'h004 && pstrb == 4'hf;
   endsequence
   sequence s_strap_quiet;
      $stable(subsys_wz_dealloc) [*5];
   endsequence
   chk_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no pready after setup");
   chk_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
   chk_ready_one_cycle: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   chk_err_unmapped: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h020))
      else $error("pslverr wrong for address");
   chk_err_zero_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("error read data not zero");
   chk_reserved_bits: assert property (deallocate_read_features[7:5] == 3'h0)
      else $error("reserved feature bits set");
   chk_read_code: assert property (pready && pwrite && paddr == 12'h000 && pstrb[0] |-> ##2
      deallocate_read_features[2:0] == (($past(pwdata[2:0], 2) > 3'h2) ? 3'h0 : $past(pwdata[2:0], 2)))
      else $error("read value code wrong");
   chk_guard_ones: assert property (!deallocate_read_features[4] && $stable(deallocate_read_features[4])
      |-> guard_value == 16'hFFFF) else $error("guard not all ones");
   chk_strap_follow: assert property (s_strap_quiet |-> deallocate_read_features[3] == subsys_wz_dealloc)
      else $error("write-zeroes bit does not follow strap");
   chk_unit_normal: assert property (s_ns_wr ##0 pwdata[15:0] != 16'h0000 |-> ##2
      eff_atomic_normal == $past(pwdata[15:0], 2)) else $error("normal unit wrong");
   chk_unit_powerfail: assert property (s_ns_wr ##0 pwdata[31:16] != 16'h0000 |-> ##2
      eff_atomic_powerfail == $past(pwdata[31:16], 2)) else $error("power-fail unit wrong");
endmodule // ndai_asserts
bind ndai_top ndai_asserts #(.AW(AW), .LBAW(LBAW)) ndai_asserts_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .subsys_wz_dealloc(subsys_wz_dealloc),
   .deallocate_read_features(deallocate_read_features), .guard_value(guard_value),
   .eff_atomic_normal(eff_atomic_normal), .eff_atomic_powerfail(eff_atomic_powerfail),
   .eff_atomic_compare_write(eff_atomic_compare_write));

//--- dv/ndai_host.sv
// Host model: APB master issuing register transfers.
// Assumes pclk from the bench; waits for pready without a cycle limit.
`timescale 1ns/10ps
module ndai_host (
   input wire pclk,
   input wire pready,
   output reg psel = 1'b0,
   output reg penable = 1'b0,
   output reg pwrite = 1'b0,
   output reg [11:0] paddr = 12'h000,
   output reg [31:0] pwdata = 32'h0000_0000,
   output reg [3:0] pstrb = 4'h0
);
   task xfer(input w, input [11:0] a, input [31:0] d, input [3:0] s);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         pstrb <= s;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         psel <= 1'b0;
         penable <= 1'b0;
         // Released address and data lines do not keep the last value
         paddr <= ~a;
         pwdata <= ~d;
      end
   endtask
endmodule // ndai_host

//--- dv/tb_top.sv
// Self-checking bench for ndai_top driven by the host model.
// Assumes ndai_host, the bound checker and a 20 MHz pclk.
`timescale 1ns/10ps
`include "ndai_defines.vh"
module tb_top;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg subsys_wz_dealloc = 1'b0;
   wire psel, penable, pwrite, pready, pslverr;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   wire [3:0] pstrb;
   wire [7:0] feat;
   wire [15:0] guard, eff_n, eff_pf, eff_cw;
   reg [33:0] notes[$];
   reg [33:0] note;
   integer bad_count = 0;
   integer total_checks = 0;
   integer seed = 5288;
   integer i;
   reg [31:0] r0, r1, r2;
   reg [15:0] crc;
   always #25 pclk = ~pclk;
   ndai_top ndai_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .subsys_wz_dealloc(subsys_wz_dealloc), .deallocate_read_features(feat), .guard_value(guard),
      .eff_atomic_normal(eff_n), .eff_atomic_powerfail(eff_pf), .eff_atomic_compare_write(eff_cw));
   ndai_host ndai_host_inst (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   function [15:0] crc_step(input [15:0] c, input [7:0] b);
      integer k;
      begin
         crc_step = c;
         for (k = 7; k >= 0; k = k - 1)
            crc_step = {crc_step[14:0], 1'b0} ^ ((crc_step[15] ^ b[k]) ? `NDAI_CRC_POLY : 16'h0000);
      end
   endfunction
   task chk(input [33:0] got, input [33:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp)
         begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task final_report;
      begin
         if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task wr(input [11:0] a, input [31:0] d, input [3:0] s);
      begin
         notes.push_back({1'b1, a > 12'h020, 32'h0000_0000});
         ndai_host_inst.xfer(1'b1, a, d, s);
      end
   endtask
   task rd(input [11:0] a, input [31:0] e);
      begin
         notes.push_back({1'b0, a > 12'h020, e});
         ndai_host_inst.xfer(1'b0, a, 32'h0000_0000, 4'h0);
      end
   endtask
   task idle(input integer n);
      repeat (n) @(posedge pclk);
   endtask
   always @(posedge pclk)
      if (pready === 1'b1)
      begin
         note = notes.pop_front();
         chk({note[33], pslverr, note[33] ? 32'h0000_0000 : prdata}, note);
      end
   // Limit well above the few hundred cycles the sequence needs
   initial
   begin
      #2000000;
      bad_count = bad_count + 1;
      final_report;
   end
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      idle(5);
      chk(feat, 8'h01);
      chk(guard, 16'hFFFF);
      rd(12'h000, 32'h0000_0001);
      r0 = $random(seed) & 32'h0000_00ff;
      wr(12'h000, 32'h0001_0011, 4'h5);
      wr(12'h000, r0 << 8, 4'h2);
      wr(12'h000, r0 << 8, 4'h2);
      crc = crc_step(crc_step(`NDAI_CRC_SEED, 8'h00), r0[7:0]);
      idle(3);
      chk(guard, crc);
      rd(12'h01C, {crc, 16'h0000});
      for (i = 0; i < 8; i = i + 1)
      begin
         r0 = ($random(seed) & 32'h0000_00e0) | i;
         wr(12'h000, r0, 4'h1);
         idle(3);
         r1 = (i < 3) ? i : 0;
         chk(feat, r1[7:0]);
         rd(12'h014, {16'h0000, r1[7:0], 8'h00});
      end
      chk(guard, 16'hFFFF);
      for (i = 0; i < 2; i = i + 1)
      begin
         @(posedge pclk);
         subsys_wz_dealloc <= ~subsys_wz_dealloc;
         wr(12'h000, {28'h000_0000, subsys_wz_dealloc, 3'h1}, 4'h1);
         idle(5);
         chk(feat, {4'h0, subsys_wz_dealloc, 3'h1});
      end
      for (i = 0; i < 2; i = i + 1)
      begin
         r0 = $random(seed);
         r1 = $random(seed) | 32'h0001_0001;
         r2 = (i == 0) ? r1 : 32'h0000_0000;
         wr(12'h00C, r0, 4'hf);
         wr(12'h010, r0, 4'hf);
         wr(12'h004, r2, 4'hf);
         wr(12'h008, r2, 4'h3);
         idle(3);
         chk(eff_n, i ? r0[15:0] : r1[15:0]);
         chk(eff_pf, i ? r0[31:16] : r1[31:16]);
         chk(eff_cw, i ? r0[15:0] : r1[15:0]);
         rd(12'h018, {r2[15:0], r2[31:16]});
      end
      for (i = 0; i < 4; i = i + 1)
      begin
         r0 = (i < 3) ? 8 : 0;
         r1 = (i == 2) ? 8 : 6;
         r2 = (i == 0) ? 1 : ((i == 2) ? 7 : 2);
         wr(12'h008, r0 << 16, 4'hc);
         wr(12'h01C, r1, 4'hf);
         wr(12'h020, r2, 4'hf);
         idle(3);
         rd(12'h01C, {16'hFFFF, 15'h0000, i == 1});
      end
      wr(12'h024, 32'hffff_ffff, 4'hf);
      rd(12'h024, 32'h0000_0000);
      idle(3);
      final_report;
   end
endmodule // tb_top
